/* hw/irs_defines.svh */
/*
  constants of the two-wire register slave port.
  assumes mclk at 100 MHz, bus inputs synchronous to it.
*/
// Functional notes
// (R1) two-wire slave mode while select pin high
// (R2) accepts 100 kHz and 400 kHz bus rates
// (R3) single and multi byte reads and writes
// (R4) strap high answers address 0x1d
// (R5) strap low answers address 0x53
// (R6) write: address, register, data; ack each
// (R7) read via pointer write then restart
// (R8) pointer advances after every data byte
`ifndef IRS_DEFINES_SVH
`define IRS_DEFINES_SVH
`define IRS_ADDR_HIGH   7'h1d
`define IRS_ADDR_LOW    7'h53
`define IRS_BIT_LAST    3'h7
`define IRS_CNT_ZERO    4'h0
`define IRS_CNT_ONE     4'h1
`define IRS_CNT_LAST    4'h7
`define IRS_CNT_BYTE    4'h8
`define IRS_BUS_IDLE    1'h1
`define IRS_MIN_OVERSAMPLE 8
`define IRS_MCLK_KHZ    100000
`define IRS_FAST_KHZ    400
`define IRS_STD_KHZ     100
`endif

/* hw/irs_pkg.sv */
/*
  types of the two-wire register slave port.
  assumes irs_defines.svh is available.
*/
package irs_pkg;
  typedef enum logic [2:0] {
    IRS_IDLE, IRS_ADDR, IRS_ACK, IRS_RX, IRS_TX, IRS_TX_ACK
  } irs_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } irs_pins_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } irs_reg_req_t;

  typedef struct packed {
    irs_state_t   st;
    irs_pins_t    prev;
    logic [7:0]   shift;
    logic [3:0]   cnt;
    logic         rw;
    logic         have_ptr;
    logic         ack_ok;
    logic [7:0]   ptr;
    logic         drive_low;
    irs_reg_req_t req;
  } irs_state_all_t;
endpackage

/* hw/irs_slave.sv */
/*
  two-wire slave giving a master access to the register file.
  assumes scl/sda synchronous to mclk, register file answers
  reg_rdata combinationally from reg_req.addr.
*/
`timescale 1ns/1ps
`include "irs_defines.svh"
module irs_slave
#(
  parameter int MCLK_KHZ = `IRS_MCLK_KHZ
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             iface_select,
  input  wire logic             bus_address_select_pin,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  output irs_pkg::irs_reg_req_t reg_req,
  input  wire logic [7:0]       reg_rdata
);
  //////////////////////////////////////////////////////////////////////
  // oversampling margin: fast mode must give 4+ mclk per scl phase,
  // or start and stop, seen over two samples, can slip past unnoticed
  if (MCLK_KHZ < `IRS_MIN_OVERSAMPLE * `IRS_FAST_KHZ)
  begin : g_mclk_check
    $error("mclk too slow for fast mode");
  end

  logic [1:0] rst_sync;
  logic       rst_q_n;
  irs_pkg::irs_state_all_t s, next_s;
  logic [6:0] my_addr;
  logic       scl_rise, scl_fall, start_c, stop_c;
  logic       byte_done;

  // pin history starts at the idle bus level, high on both lines, so
  // the first cycles after reset see no false edge, start or stop
  localparam irs_pkg::irs_state_all_t reset_state = '{
    st:        irs_pkg::IRS_IDLE,
    prev:      '{scl: `IRS_BUS_IDLE, sda: `IRS_BUS_IDLE},
    shift:     8'h00,
    cnt:       `IRS_CNT_ZERO,
    rw:        1'h0,
    have_ptr:  1'h0,
    ack_ok:    1'h0,
    ptr:       8'h00,
    drive_low: 1'h0,
    req:       '{addr: 8'h00, wdata: 8'h00, we: 1'h0, re: 1'h0}
  };

  //////////////////////////////////////////////////////////////////////
  // reset asserts at once but is released through two flops

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'h1};
  end
  assign rst_q_n = rst_sync[1];

  //////////////////////////////////////////////////////////////////////
  // condition detection on sampled pins, valid at both bus rates [R2]
  assign my_addr  = bus_address_select_pin ? `IRS_ADDR_HIGH // [R4]
                                           : `IRS_ADDR_LOW; // [R5]
  assign scl_rise = scl_in & ~s.prev.scl;
  assign scl_fall = ~scl_in & s.prev.scl;
  assign start_c  = scl_in & s.prev.scl & s.prev.sda & ~sda_in;
  assign stop_c   = scl_in & s.prev.scl & ~s.prev.sda & sda_in;
  // eight rises counted: the fall that ends a start condition comes
  // with no bit counted and so never closes a byte
  assign byte_done = scl_fall & (s.cnt == `IRS_CNT_BYTE);

  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s          = s;
    next_s.prev.scl = scl_in;
    next_s.prev.sda = sda_in;
    next_s.req.we   = 1'h0;
    next_s.req.re   = 1'h0;
    if (!iface_select) // [R1]
    begin
      next_s.st        = irs_pkg::IRS_IDLE;
      next_s.drive_low = 1'h0;
    end
    else if (start_c) // repeated start keeps the pointer [R7]
    begin
      next_s.st        = irs_pkg::IRS_ADDR;
      next_s.cnt       = `IRS_CNT_ZERO;
      next_s.drive_low = 1'h0;
    end
    else if (stop_c)
    begin
      next_s.st        = irs_pkg::IRS_IDLE;
      next_s.drive_low = 1'h0;
    end
    else
    begin
      unique case (s.st)
        irs_pkg::IRS_IDLE:
          next_s.drive_low = 1'h0;
        irs_pkg::IRS_ADDR:
          if (scl_rise)
          begin
            next_s.shift = {s.shift[6:0], sda_in};
            next_s.cnt   = s.cnt + `IRS_CNT_ONE;
          end
          else if (byte_done)
          begin
            // address byte in: acknowledge only our own address
            next_s.ack_ok    = (s.shift[7:1] == my_addr); // [R4] [R5]
            next_s.rw        = s.shift[0];
            next_s.have_ptr  = 1'h0;
            next_s.drive_low = next_s.ack_ok; // [R6]
            next_s.st        = next_s.ack_ok ? irs_pkg::IRS_ACK
                                             : irs_pkg::IRS_IDLE;
          end
        irs_pkg::IRS_RX:
          if (scl_rise)
          begin
            next_s.shift = {s.shift[6:0], sda_in};
            next_s.cnt   = s.cnt + `IRS_CNT_ONE;
          end
          else if (byte_done)
          begin
            // first byte sets the pointer, later ones are data
            next_s.ack_ok = 1'h1;
            if (!s.have_ptr)
            begin
              next_s.ptr      = s.shift;
              next_s.have_ptr = 1'h1;
            end
            else
            begin
              next_s.req.addr  = s.ptr; // [R3] [R6]
              next_s.req.wdata = s.shift;
              next_s.req.we    = 1'h1;
              next_s.ptr       = s.ptr + 8'h1; // [R8]
            end
            next_s.drive_low = 1'h1; // [R6]
            next_s.st        = irs_pkg::IRS_ACK;
          end
        irs_pkg::IRS_ACK:
          if (scl_fall)
          begin
            next_s.cnt = `IRS_CNT_ZERO;
            if (s.rw)
            begin
              // reg_rdata already shows the pointer's register, since
              // the request address follows the pointer [R7]
              next_s.shift     = reg_rdata;
              next_s.req.addr  = s.ptr;
              next_s.req.re    = 1'h1;
              next_s.ptr       = s.ptr + 8'h1; // [R8]
              next_s.drive_low = ~reg_rdata[`IRS_BIT_LAST];
              next_s.st        = irs_pkg::IRS_TX;
            end
            else
            begin
              next_s.drive_low = 1'h0;
              next_s.st        = irs_pkg::IRS_RX;
            end
          end
        irs_pkg::IRS_TX:
          if (scl_fall)
          begin
            next_s.cnt = s.cnt + `IRS_CNT_ONE;
            if (s.cnt == `IRS_CNT_LAST)
            begin
              next_s.drive_low = 1'h0; // release for master ack
              next_s.st        = irs_pkg::IRS_TX_ACK;
            end
            else
            begin
              next_s.shift     = {s.shift[6:0], 1'h0};
              next_s.drive_low = ~s.shift[6];
            end
          end
        irs_pkg::IRS_TX_ACK:
          if (scl_rise)
            // nack ends the read; master then stops [R7]
            next_s.st = sda_in ? irs_pkg::IRS_IDLE : irs_pkg::IRS_ACK;
      endcase
    end
    // between strobes the request address tracks the pointer, so the
    // register file shows read data before the byte is loaded
    if (!next_s.req.we && !next_s.req.re)
      next_s.req.addr = next_s.ptr; // [R8]
  end

  always_ff @(posedge mclk or negedge rst_q_n)
  begin
    if (!rst_q_n)
      s <= reset_state;
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////
  // open drain: only ever pull low
  assign sda_out = 1'h0;
  assign sda_oe  = s.drive_low;
  assign reg_req = s.req;
endmodule

/* test/irs_slave_sva.sv */
/* pin checker for the slave port.
   assumes it is bound onto irs_slave. */
`timescale 1ns/1ps
module irs_slave_sva (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  iface_select,
  input wire logic                  scl_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe,
  input wire irs_pkg::irs_reg_req_t reg_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_ack; ##[0:3] sda_oe; endsequence
  property p_low; sda_out == 1'b0; endproperty
  property p_off; !iface_select [*3] |-> !sda_oe && !reg_req.we; endproperty
  property p_stab; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
  property p_rise; $rose(sda_oe) |-> !scl_in; endproperty
  property p_fall; $fell(sda_oe) |-> !scl_in; endproperty
  property p_we; reg_req.we |=> !reg_req.we; endproperty
  property p_re; reg_req.re |=> !reg_req.re; endproperty
  property p_wack; $rose(reg_req.we) |-> s_ack; endproperty
  a_low: assert property (p_low) else $error("sda_out high");
  a_off: assert property (p_off) else $error("active deselected");
  a_stab: assert property (p_stab) else $error("sda moved, scl high");
  a_rise: assert property (p_rise) else $error("drive at scl high");
  a_fall: assert property (p_fall) else $error("release at scl high");
  a_we: assert property (p_we) else $error("long write pulse");
  a_re: assert property (p_re) else $error("long read pulse");
  a_wack: assert property (p_wack) else $error("data not acked");
endmodule

/* test/irs_master_model.sv */
/* bus master model for the slave port.
   assumes a pull-up on sda; moves just after mclk rises. */
`timescale 1ns/1ps
module irs_master_model (
  input  wire logic mclk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic drv = 1'b1;
  int   q   = 63;
  // released line floats to the pull-up level
  assign sda = drv & ~sda_oe;
  initial scl = 1'b1;
  // quarter bit of q cycles: 63 near 400 kHz, 250 gives 100 kHz
  task automatic tk(input logic s, input logic d);
    scl = s;
    drv = d;
    repeat (q) @(posedge mclk);
    #1;
  endtask
  task automatic start;
    tk(0, 1);
    tk(1, 1);
    tk(1, 0);
    tk(0, 0);
  endtask
  task automatic stop;
    tk(0, 0);
    tk(1, 0);
    tk(1, 1);
  endtask
  // r[8:1] data seen, r[0] acknowledge seen
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [8:0] r);
    logic [8:0] w;
    w = {d, a};
    for (int i = 8; i >= 0; i--)
    begin
      tk(0, w[i]);
      tk(1, w[i]);
      r[i] = sda;
      tk(1, w[i]);
      tk(0, w[i]);
    end
  endtask
endmodule

/* test/tb_i2c_register_slave_port.sv */
/* self-checking bench for the slave port.
   assumes the master model and the bound checker. */
`timescale 1ns/1ps
module tb_i2c_register_slave_port;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b1;
  logic strap = 1'b1;
  logic scl, sda, sda_out, sda_oe;
  logic [7:0] rdata;
  logic [8:0] r;
  logic [15:0] wq[$];
  logic [7:0] rq[$];
  int bad_count = 0;
  int samples_checked = 0;
  irs_pkg::irs_reg_req_t req;
  // read data is a fixed function of the pointer
  assign rdata = req.addr ^ 8'h5a;
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) if (req.we === 1'b1) wq.push_back(req[17:2]);
  always @(posedge mclk) if (req.re === 1'b1) rq.push_back(req.addr);
  irs_slave uut (.mclk(mclk), .rst_n(rst_n), .iface_select(sel),
    .bus_address_select_pin(strap), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_req(req), .reg_rdata(rdata));
  irs_master_model m (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_write;
    m.q = 250;
    m.start();
    m.xfer(8'h3a, 1, r);
    check(r[0], 0);
    m.xfer(8'h10, 1, r);
    check(r[0], 0);
    m.xfer(8'ha5, 1, r);
    check(r[0], 0);
    m.xfer(8'h3c, 1, r);
    check(r[0], 0);
    m.stop();
    m.q = 63;
    check(16'(wq.size()), 2);
    check(wq[0], 16'h10a5);
    check(wq[1], 16'h113c);
    $display("write test done");
  endtask
  task automatic t_read;
    strap = 1'b0;
    m.start();
    m.xfer(8'ha6, 1, r);
    check(r[0], 0);
    m.xfer(8'hff, 1, r);
    check(r[0], 0);
    m.start();
    m.xfer(8'ha7, 1, r);
    check(r[0], 0);
    m.xfer(8'hff, 0, r);
    check(r[8:1], 8'ha5);
    m.xfer(8'hff, 1, r);
    check(r[8:1], 8'h5a);
    m.stop();
    check(16'(rq.size()), 16'h2);
    check(rq[0], 8'hff);
    check(rq[1], 8'h00);
    $display("read test done");
  endtask
  task automatic t_refuse;
    strap = 1'b1;
    m.start();
    m.xfer(8'ha6, 1, r);
    check(r[0], 1);
    m.stop();
    sel = 1'b0;
    m.start();
    m.xfer(8'h3a, 1, r);
    check(r[0], 1);
    m.stop();
    check(16'(wq.size()), 2);
    $display("refuse test done");
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    t_write();
    t_read();
    t_refuse();
    results();
  end
endmodule
bind irs_slave irs_slave_sva chk (.mclk(mclk), .rst_n(rst_n),
  .iface_select(iface_select), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .reg_req(reg_req));
